// ---- tabx_pkg.sv ----
// constants and types of the table and xor executor
`default_nettype none
package tabx_pkg;
  localparam int PTR_W = 21;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int HOLD_N = 8;
  localparam int HOLD_IDX_W = 3;
  localparam int BANK_W = 4;
  localparam int FADDR_W = 12;
  localparam int PM_WORD_W = 16;
  localparam int PM_ADDR_W = 20;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  localparam logic [11:0] OPC_TBL_HI = 12'h000;
  localparam logic [1:0] OPC_TBL_RD = 2'h2;
  localparam logic [1:0] OPC_TBL_WR = 2'h3;
  localparam logic [7:0] OPC_XORL = 8'h0a;
  localparam logic [5:0] OPC_XORF = 6'h06;
  localparam logic [6:0] OPC_TSTZ = 7'h33;

  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_INC = 2'h3;

  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  localparam logic [AXI_AW-1:0] REG_PTR = 8'h00;
  localparam logic [AXI_AW-1:0] REG_LATCH = 8'h04;
  localparam logic [AXI_AW-1:0] REG_WREG = 8'h08;
  localparam logic [AXI_AW-1:0] REG_BANK = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h10;
  localparam logic [AXI_AW-1:0] REG_HOLD_BASE = 8'h20;
  localparam logic [AXI_AW-1:0] REG_HOLD_MASK = 8'he0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [PTR_W-1:0] PTR_RST = 21'h0_0000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 21'h0_0001;

  typedef enum logic [1:0] {PH_Q1 = 2'h0, PH_Q2 = 2'h1, PH_Q3 = 2'h3, PH_Q4 = 2'h2} tabx_phase_e;
  typedef enum logic [1:0] {EX_C1 = 2'h0, EX_C2 = 2'h1, EX_C3 = 2'h3} tabx_exec_e;
  typedef enum logic [2:0] {OP_NONE, OP_TABLE_READ_OP, OP_TABLE_WRITE_OP, OP_XORL, OP_XORF, OP_TSTZ} tabx_op_e;

  typedef struct packed {
    logic [FADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } tabx_file_req_s;

  typedef struct packed {
    logic [PM_ADDR_W-1:0] addr;
    logic rd;
  } tabx_pm_req_s;
endpackage
`default_nettype wire

// ---- tabx_hold_bank.sv ----
// eight byte holding registers loaded by table writes
`timescale 1ns/100ps
`default_nettype none
module tabx_hold_bank
  import tabx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [HOLD_IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [HOLD_IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] hold_r [HOLD_N];

  genvar gi;
  generate
    for (gi = 0; gi < HOLD_N; gi++)
    begin : g_hold
      logic [DATA_W-1:0] hold_nxt;
      always_comb
      begin
        hold_nxt = hold_r[gi];
        if (wr_en && (wr_idx == HOLD_IDX_W'(gi)))
          hold_nxt = wr_data;
      end
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          hold_r[gi] <= BYTE_RST;
        else if (ce)
          hold_r[gi] <= hold_nxt;
      end
    end
  endgenerate

  assign rd_data = hold_r[rd_idx];
endmodule
`default_nettype wire

// ---- tabx_core.sv ----
// table access, test-skip and xor execution with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tabx_core
  import tabx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  output logic instr_ready,
  input wire logic next_two_word,
  output logic discard_next,
  output tabx_pm_req_s pm_req,
  input wire logic [PM_WORD_W-1:0] pm_rdata,
  output tabx_file_req_s file_req,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // opcode decode
  function automatic tabx_op_e tabx_decode(input logic [INSTR_W-1:0] iw);
    tabx_op_e op;
    op = OP_NONE;
    if (iw[15:4] == OPC_TBL_HI && iw[3:2] == OPC_TBL_RD)
      op = OP_TABLE_READ_OP;
    else if (iw[15:4] == OPC_TBL_HI && iw[3:2] == OPC_TBL_WR)
      op = OP_TABLE_WRITE_OP;
    else if (iw[15:8] == OPC_XORL)
      op = OP_XORL;
    else if (iw[15:10] == OPC_XORF)
      op = OP_XORF;
    else if (iw[15:9] == OPC_TSTZ)
      op = OP_TSTZ;
    return op;
  endfunction

  // bank selection for file operands
  function automatic logic [FADDR_W-1:0] tabx_file_addr(input logic acc, input logic [7:0] f,
                                                         input logic [BANK_W-1:0] bank_select_register);
    logic [BANK_W-1:0] bank;
    bank = bank_select_register;
    if (!acc)
      bank = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
    return {bank, f};
  endfunction

  // byte-lane merge of a write
  function automatic logic [AXI_DW-1:0] tabx_merge(input logic [AXI_DW-1:0] old_v,
                                                   input logic [AXI_DW-1:0] new_v,
                                                   input logic [3:0] strb);
    logic [AXI_DW-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  tabx_phase_e q_r, q_nxt;
  tabx_exec_e ex_r, ex_nxt;
  tabx_op_e op_r, op_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic dest_r, dest_nxt;
  logic [DATA_W-1:0] lit_r, lit_nxt;
  logic [DATA_W-1:0] opnd_r, opnd_nxt;
  logic skip_two_r, skip_two_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic [DATA_W-1:0] latch_r, latch_nxt;
  logic [DATA_W-1:0] w_r, w_nxt;
  logic [BANK_W-1:0] bsr_r, bsr_nxt;
  logic n_r, n_nxt;
  logic z_r, z_nxt;
  logic ready_r, ready_nxt;
  logic discard_r, discard_nxt;
  tabx_pm_req_s pm_r, pm_nxt;
  tabx_file_req_s file_r, file_nxt;
  logic hold_we;
  logic [DATA_W-1:0] hold_rd;
  tabx_op_e dec_op;

  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
  logic [AXI_DW-1:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [AXI_DW-1:0] rdata_r, rdata_nxt;
  logic wr_fire;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic busy;

  assign dec_op = tabx_decode(instr_word);
  assign busy = (ex_r != EX_C1) || (op_r != OP_NONE);

  assign hold_we = ce && q_r == PH_Q4 && ex_r == EX_C2 && op_r == OP_TABLE_WRITE_OP;

  tabx_hold_bank u_hold (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(hold_we),
    .wr_idx(ptr_r[HOLD_IDX_W-1:0]),
    .wr_data(opnd_r),
    .rd_idx(s_axi_araddr[HOLD_IDX_W+1:2]),
    .rd_data(hold_rd)
  );

  // execution sequencing
  always_comb
  begin
    q_nxt = q_r;
    ex_nxt = ex_r;
    op_nxt = op_r;
    mode_nxt = mode_r;
    dest_nxt = dest_r;
    lit_nxt = lit_r;
    opnd_nxt = opnd_r;
    skip_two_nxt = skip_two_r;
    ptr_nxt = ptr_r;
    latch_nxt = latch_r;
    w_nxt = w_r;
    bsr_nxt = bsr_r;
    n_nxt = n_r;
    z_nxt = z_r;
    discard_nxt = 1'b0;
    pm_nxt = pm_r;
    pm_nxt.rd = 1'b0;
    file_nxt = file_r;
    file_nxt.rd = 1'b0;
    file_nxt.wr = 1'b0;
    if (wr_fire)
    begin
      unique case (wr_addr)
        REG_PTR: ptr_nxt = PTR_W'(tabx_merge({11'h000, ptr_r}, wr_data, wr_strb));
        REG_LATCH: latch_nxt = DATA_W'(tabx_merge({24'h00_0000, latch_r}, wr_data, wr_strb));
        REG_WREG: w_nxt = DATA_W'(tabx_merge({24'h00_0000, w_r}, wr_data, wr_strb));
        REG_BANK: bsr_nxt = BANK_W'(tabx_merge({28'h000_0000, bsr_r}, wr_data, wr_strb));
        default: ;
      endcase
    end
    unique case (q_r)
      PH_Q1: q_nxt = PH_Q2;
      PH_Q2: q_nxt = PH_Q3;
      PH_Q3: q_nxt = PH_Q4;
      PH_Q4: q_nxt = PH_Q1;
    endcase
    unique case (ex_r)
      EX_C1:
      begin
        unique case (q_r)
          PH_Q1:
          begin
            op_nxt = (instr_valid && ready_r) ? dec_op : OP_NONE;
            mode_nxt = instr_word[1:0];
            dest_nxt = instr_word[9];
            lit_nxt = instr_word[7:0];
            file_nxt.addr = tabx_file_addr(instr_word[8], instr_word[7:0], bsr_r);
            file_nxt.rd = instr_valid && ready_r && (dec_op == OP_XORF || dec_op == OP_TSTZ);
          end
          PH_Q2:
            opnd_nxt = (op_r == OP_XORL) ? lit_r : file_rdata;
          PH_Q3:
          begin
            if (op_r == OP_XORL || op_r == OP_XORF)
            begin
              opnd_nxt = w_r ^ opnd_r;
              file_nxt.wdata = w_r ^ opnd_r;
              file_nxt.wr = (op_r == OP_XORF) && dest_r;
            end
            skip_two_nxt = next_two_word;
          end
          PH_Q4:
          begin
            // xor result (literal, or file with dest clear) to w; literal and file xor result to n and z
            if (op_r == OP_XORL || (op_r == OP_XORF && !dest_r))
              w_nxt = opnd_r;
            if (op_r == OP_XORL || op_r == OP_XORF)
            begin
              n_nxt = opnd_r[DATA_W-1];
              z_nxt = (opnd_r == BYTE_RST);
            end
            if ((op_r == OP_TABLE_READ_OP || op_r == OP_TABLE_WRITE_OP) && mode_r == MODE_PRE_INC)
              ptr_nxt = ptr_r + PTR_ONE;
            if (op_r == OP_TABLE_READ_OP || op_r == OP_TABLE_WRITE_OP)
              ex_nxt = EX_C2;
            if (op_r == OP_TSTZ && opnd_r == BYTE_RST)
            begin
              discard_nxt = 1'b1;
              ex_nxt = EX_C2;
            end
            else if (op_r == OP_TSTZ)
              op_nxt = OP_NONE;
          end
        endcase
      end
      EX_C2:
      begin
        unique case (q_r)
          PH_Q1:
          begin
            pm_nxt.addr = ptr_r[PTR_W-1:1];
            pm_nxt.rd = (op_r == OP_TABLE_READ_OP);
          end
          PH_Q2:
          begin
            if (op_r == OP_TABLE_READ_OP)
              opnd_nxt = ptr_r[0] ? pm_rdata[PM_WORD_W-1:DATA_W] : pm_rdata[DATA_W-1:0];
            else if (op_r == OP_TABLE_WRITE_OP)
              opnd_nxt = latch_r;
          end
          PH_Q3: ;
          PH_Q4:
          begin
            if (op_r == OP_TABLE_READ_OP)
              latch_nxt = opnd_r;
            if ((op_r == OP_TABLE_READ_OP || op_r == OP_TABLE_WRITE_OP) && mode_r == MODE_POST_INC)
              ptr_nxt = ptr_r + PTR_ONE;
            if ((op_r == OP_TABLE_READ_OP || op_r == OP_TABLE_WRITE_OP) && mode_r == MODE_POST_DEC)
              ptr_nxt = ptr_r - PTR_ONE;
            ex_nxt = (op_r == OP_TSTZ && skip_two_r) ? EX_C3 : EX_C1;
            if (!(op_r == OP_TSTZ && skip_two_r))
              op_nxt = OP_NONE;
          end
        endcase
      end
      EX_C3:
      begin
        if (q_r == PH_Q4)
        begin
          ex_nxt = EX_C1;
          op_nxt = OP_NONE;
        end
      end
      default:
        ex_nxt = EX_C1;
    endcase
    ready_nxt = (q_nxt == PH_Q1) && (ex_nxt == EX_C1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q_r <= PH_Q1;
      ex_r <= EX_C1;
      op_r <= OP_NONE;
      mode_r <= MODE_KEEP;
      dest_r <= 1'b0;
      lit_r <= BYTE_RST;
      opnd_r <= BYTE_RST;
      skip_two_r <= 1'b0;
      ptr_r <= PTR_RST;
      latch_r <= BYTE_RST;
      w_r <= BYTE_RST;
      bsr_r <= BANK_RST;
      n_r <= 1'b0;
      z_r <= 1'b0;
      ready_r <= 1'b1;
      discard_r <= 1'b0;
      pm_r <= '0;
      file_r <= '0;
    end
    else if (ce)
    begin
      q_r <= q_nxt;
      ex_r <= ex_nxt;
      op_r <= op_nxt;
      mode_r <= mode_nxt;
      dest_r <= dest_nxt;
      lit_r <= lit_nxt;
      opnd_r <= opnd_nxt;
      skip_two_r <= skip_two_nxt;
      ptr_r <= ptr_nxt;
      latch_r <= latch_nxt;
      w_r <= w_nxt;
      bsr_r <= bsr_nxt;
      n_r <= n_nxt;
      z_r <= z_nxt;
      ready_r <= ready_nxt;
      discard_r <= discard_nxt;
      pm_r <= pm_nxt;
      file_r <= file_nxt;
    end
  end

  // axi4-lite slave
  always_comb
  begin
    aw_got_nxt = aw_got_r || (s_axi_awvalid && awready_r);
    w_got_nxt = w_got_r || (s_axi_wvalid && wready_r);
    awaddr_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb : wstrb_r;
    wr_addr = awaddr_nxt;
    wr_data = wdata_nxt;
    wr_strb = wstrb_nxt;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    wr_fire = aw_got_nxt && w_got_nxt && !bvalid_r;
    if (wr_fire)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_addr == REG_PTR || wr_addr == REG_LATCH || wr_addr == REG_WREG ||
                   wr_addr == REG_BANK) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      if ((s_axi_araddr & REG_HOLD_MASK) == REG_HOLD_BASE)
        rdata_nxt = {24'h00_0000, hold_rd};
      else
      begin
        unique case (s_axi_araddr)
          REG_PTR: rdata_nxt = {11'h000, ptr_r};
          REG_LATCH: rdata_nxt = {24'h00_0000, latch_r};
          REG_WREG: rdata_nxt = {24'h00_0000, w_r};
          REG_BANK: rdata_nxt = {28'h000_0000, bsr_r};
          REG_STATUS: rdata_nxt = {29'h0000_0000, busy, z_r, n_r};
          default: rresp_nxt = RESP_SLVERR;
        endcase
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end
    else if (ce)
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign instr_ready = ready_r;
  assign discard_next = discard_r;
  assign pm_req = pm_r;
  assign file_req = file_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- tabx_props.sv ----
// assertion checker for the table and xor executor
`timescale 1ns/100ps
`default_nettype none
module tabx_props
  import tabx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic discard_next,
  input wire tabx_pm_req_s pm_req,
  input wire tabx_file_req_s file_req
);
  logic [15:0] w;
  logic tk, t_rd, t_wt, t_xl, t_xf, t_ts;
  assign w = instr_word;
  assign tk = instr_ready && instr_valid;
  assign t_rd = tk && w[15:2] == {OPC_TBL_HI, OPC_TBL_RD};
  assign t_wt = tk && w[15:2] == {OPC_TBL_HI, OPC_TBL_WR};
  assign t_xl = tk && w[15:8] == OPC_XORL;
  assign t_xf = tk && w[15:10] == OPC_XORF;
  assign t_ts = tk && w[15:9] == OPC_TSTZ;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_xl_len;
    t_xl |=> !instr_ready [*3] ##1 instr_ready;
  endproperty
  a_xl_len: assert property (p_xl_len) else $error("xor literal length wrong");
  property p_rd_len;
    t_rd |=> !instr_ready [*7] ##1 instr_ready;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("table read length wrong");
  property p_rd_fetch;
    t_rd |=> !pm_req.rd [*4] ##1 pm_req.rd ##1 !pm_req.rd;
  endproperty
  a_rd_fetch: assert property (p_rd_fetch) else $error("program read slot wrong");
  property p_wt_only;
    t_wt |=> (!pm_req.rd && !file_req.wr) [*7] ##1 instr_ready;
  endproperty
  a_wt_only: assert property (p_wt_only) else $error("table write side effect");
  property p_xf_read;
    t_xf |=> file_req.rd ##1 !file_req.rd;
  endproperty
  a_xf_read: assert property (p_xf_read) else $error("file read slot wrong");
  property p_xf_dest;
    t_xf && w[9] |-> ##3 file_req.wr;
  endproperty
  a_xf_dest: assert property (p_xf_dest) else $error("file write missing");
  property p_no_wr;
    t_ts || t_xl || (t_xf && !w[9]) |=> !file_req.wr [*4];
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("unexpected file write");
  property p_acc;
    (t_xf || t_ts) && !w[8] |=> file_req.addr == {$past(w[7]) ? ACCESS_HI_BANK : ACCESS_LO_BANK, $past(w[7:0])};
  endproperty
  a_acc: assert property (p_acc) else $error("access bank address wrong");
  property p_skip;
    discard_next |-> $past(t_ts, 4) ##1 !discard_next;
  endproperty
  a_skip: assert property (p_skip) else $error("discard pulse wrong");
  c_skip: cover property (discard_next);
  c_rd: cover property (t_rd);
  c_xf_wr: cover property (t_xf && w[9]);
endmodule
`default_nettype wire

// ---- tabx_mem_model.sv ----
// program memory and data file model facing the executor
`timescale 1ns/100ps
`default_nettype none
module tabx_mem_model
  import tabx_pkg::*;
(
  input wire logic sys_clk,
  input wire tabx_pm_req_s pm_req,
  output logic [PM_WORD_W-1:0] pm_rdata,
  input wire tabx_file_req_s file_req,
  output logic [DATA_W-1:0] file_rdata
);
  logic [DATA_W-1:0] fmem [0:4095];
  logic [7:0] junk = 8'h00;
  function automatic logic [15:0] pm_word(input logic [19:0] a);
    return {a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]}, a[7:0] ^ 8'h3c};
  endfunction
  // idle lines carry a changing pattern
  always @(posedge sys_clk)
  begin
    junk <= junk + 8'h01;
    if (file_req.wr)
      fmem[file_req.addr] <= file_req.wdata;
  end
  assign pm_rdata = pm_req.rd ? pm_word(pm_req.addr) : {junk, ~junk};
  assign file_rdata = file_req.rd ? fmem[file_req.addr] : junk ^ 8'h5a;
endmodule
`default_nettype wire

// ---- tb_table_access_and_xor_test_ops.sv ----
// self-checking bench for the table and xor executor
`timescale 1ns/100ps
`default_nettype none
module tb_table_access_and_xor_test_ops
  import tabx_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0, next_two_word = 1'b0, ce = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic instr_ready, discard_next, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] pm_rdata;
  logic [7:0] file_rdata;
  tabx_pm_req_s pm_req;
  tabx_file_req_s file_req;
  int errors = 0, checks = 0, dcnt = 0;
  logic [15:0] seed = 16'h4ecf;
  tabx_core dut (.sys_clk, .rst, .ce, .instr_valid, .instr_word, .instr_ready, .next_two_word,
    .discard_next, .pm_req, .pm_rdata, .file_req, .file_rdata, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  tabx_mem_model u_mem (.sys_clk, .pm_req, .pm_rdata, .file_req, .file_rdata);
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk)
  begin
    if (discard_next === 1'b1)
      dcnt++;
  end
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [7:0] pm_byte(input logic [20:0] p);
    return p[0] ? p[8:1] ^ p[16:9] ^ {4'h0, p[20:17]} : p[8:1] ^ 8'h3c;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wset(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (ap || wp)
    begin
      @(negedge sys_clk);
      ap = ap && s_axi_awready !== 1'b1;
      wp = wp && s_axi_wready !== 1'b1;
      @(posedge sys_clk);
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end
    do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [15:0] w, input logic tw, input int cyc, input int dex);
    int k, d0;
    d0 = dcnt;
    @(posedge sys_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    next_two_word <= tw;
    do @(negedge sys_clk); while (instr_ready !== 1'b1);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
    for (k = 1; instr_ready !== 1'b1; k++)
      @(negedge sys_clk);
    chk(k, 4 * cyc);
    chk(dcnt - d0, dex);
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  initial
  begin
    logic [15:0] r, s, t, w;
    logic [20:0] ptr;
    logic [7:0] lat, wreg, f, fv, res;
    logic [3:0] bnk;
    logic [11:0] fa;
    logic [2:0] op, hi;
    logic [1:0] m;
    logic n, z;
    int k;
    n = 1'b0;
    z = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int j = 0; j < 5; j++)
      rchk(8'(j * 4), 32'h0000_0000, RESP_OKAY);
    rchk(8'h14, 32'h0000_0000, RESP_SLVERR);
    wset(REG_STATUS, 32'h0000_0003, RESP_SLVERR);
    wset(REG_HOLD_BASE, 32'h0000_00ff, RESP_SLVERR);
    // clock enable low freezes the phases
    do @(negedge sys_clk); while (instr_ready !== 1'b1);
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (5)
    begin
      @(negedge sys_clk);
      chk(instr_ready, 1'b0);
    end
    @(posedge sys_clk);
    ce <= 1'b1;
    @(negedge sys_clk);
    for (k = 1; instr_ready !== 1'b1; k++)
      @(negedge sys_clk);
    chk(k, 4);
    for (int i = 0; i < 80; i++)
    begin
      r = rnd();
      s = rnd();
      t = rnd();
      ptr = i < 8 ? (i[0] ? 21'h1f_ffff : 21'h00_0000) : {r[4:0], s};
      lat = s[7:0];
      wreg = s[15:8];
      bnk = r[15:12];
      wset(REG_PTR, {r[15:5], ptr}, RESP_OKAY);
      wset(REG_LATCH, {s, s}, RESP_OKAY);
      wset(REG_WREG, {r, s[7:0], s[15:8]}, RESP_OKAY);
      wset(REG_BANK, {r, s[11:0], bnk}, RESP_OKAY);
      op = i < 8 ? 3'(3 + i[2]) : 3'(t[2:0] % 5);
      m = i < 8 ? i[1:0] : t[4:3];
      f = t[15:8];
      fa = t[5] ? {bnk, f} : {f[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
      fv = r[6] ? 8'h00 : r[15:8] ^ s[7:0];
      u_mem.fmem[fa] = fv;
      res = wreg ^ (op == 0 ? f : fv);
      if (op < 2)
      begin
        n = res[7];
        z = res == 8'h00;
        if (op == 0 || !t[6])
          wreg = res;
      end
      w = op == 0 ? {OPC_XORL, f} : op == 1 ? {OPC_XORF, t[6], t[5], f} : op == 2 ? {OPC_TSTZ, t[5], f}
        : {OPC_TBL_HI, op == 3 ? OPC_TBL_RD : OPC_TBL_WR, m};
      if (op > 2)
      begin
        if (m == MODE_PRE_INC)
          ptr++;
        hi = ptr[2:0];
        if (op == 3)
          lat = pm_byte(ptr);
        if (m == MODE_POST_INC)
          ptr++;
        if (m == MODE_POST_DEC)
          ptr--;
      end
      run(w, t[7], op > 2 ? 2 : (op == 2 && fv == 8'h00) ? (t[7] ? 3 : 2) : 1,
        int'(op == 2 && fv == 8'h00));
      if (op == 1 || op == 2)
        chk(u_mem.fmem[fa], (op == 1 && t[6]) ? res : fv);
      if (op == 4)
        rchk(REG_HOLD_BASE + {3'b000, hi, 2'b00}, {24'h00_0000, lat}, RESP_OKAY);
      rchk(REG_PTR, {11'h000, ptr}, RESP_OKAY);
      rchk(REG_LATCH, {24'h00_0000, lat}, RESP_OKAY);
      rchk(REG_WREG, {24'h00_0000, wreg}, RESP_OKAY);
      rchk(REG_STATUS, {30'h0000_0000, z, n}, RESP_OKAY);
    end
    final_report();
  end
endmodule
bind tabx_core tabx_props u_props (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .discard_next(discard_next), .pm_req(pm_req),
  .file_req(file_req));
`default_nettype wire
